// ===== core/qasoc_top.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module qasoc_top
    import qasoc_pkg::*;
#(
    parameter int NCH         = 4,
    parameter int WAKE_CYCLES = WAKE_CYC
)(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    input  wire logic             power_down_pin,
    input  wire logic             serial_io_drive_mode_strap,
    input  wire logic [NCH*8-1:0] adc_data,
    output logic                  sample_take,
    output logic      [NCH-1:0]   lane_data,
    output logic      [NCH-1:0]   lane_oe_n,
    output logic                  bit_clock_output,
    output logic                  bit_clock_output_oe_n,
    output logic                  frame_clock_output,
    output logic                  frame_clock_output_oe_n,
    output logic                  low_swing,
    output logic                  high_drive,
    output logic                  pll_low_rate,
    output logic                  pll_enable,
    output logic                  analog_enable
);

    if (NCH < 1 || NCH > 8)
    begin : g_chk_nch
        $error("NCH must be 1 to 8");
    end
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 16777215)
    begin : g_chk_wake
        $error("WAKE_CYCLES must fit 24 bits");
    end

    localparam logic [23:0] WAKE_MAX = 24'(WAKE_CYCLES);
    localparam logic [4:0]  SWAKE_N  = 5'(STBY_WAKE_CYC);
    localparam logic [2:0]  CELL_END = 3'(CELL_CYC - 1);

    // Length code 0..3 stands for 8, 10, 12 and 14 bits.
    function automatic logic [13:0] fit(input logic [13:0] v, input logic [1:0] lc);
        fit = v >> (4'd6 - {1'b0, lc, 1'b0});
    endfunction : fit

    function automatic logic [13:0] len_mask(input logic [1:0] lc);
        len_mask = fit(PAT_ONES, lc);
    endfunction : len_mask

    // The 12-bit length is padded with four trailing zeros on the wire.
    function automatic logic [4:0] frame_bits(input logic [1:0] lc);
        frame_bits = (lc == 2'd2) ? 5'd16 : (5'd8 + {2'b00, lc, 1'b0});
    endfunction : frame_bits

    // Runs a Fibonacci LFSR one bit per word bit; returns {state, word}.
    function automatic logic [36:0] pn_run(input logic [22:0] s, input int n, input int t,
                                           input logic [1:0] lc);
        logic [22:0] st;
        logic [13:0] w;
        logic        fb;
        st = s;
        w  = '0;
        for (int i = 0; i < 14; i++)
        begin
            if (i < 8 + 2 * int'(lc))
            begin
                fb = st[n-1] ^ st[t-1];
                st = ((st << 1) | {22'h0, fb}) & (23'h7FFFFF >> (23 - n));
                w  = {w[12:0], fb};
            end
        end
        pn_run = {st, w};
    endfunction : pn_run

    // Input synchronisers.
    logic pd_s1_q, pd_s2_q, strap_s1_q, strap_s2_q;
    logic [1:0] strap_wait_q;
    logic       strap_lat_q;
    localparam logic [1:0] STRAP_END = 2'(STRAP_SYNC_CYC);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pd_s1_q    <= 1'b0;
            pd_s2_q    <= 1'b0;
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end
        else if (ce)
        begin
            pd_s1_q    <= power_down_pin;
            pd_s2_q    <= pd_s1_q;
            strap_s1_q <= serial_io_drive_mode_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // The strap is caught once the synchroniser has filled after reset, then ignored.
    // Latching on the first edge would only see the synchroniser's reset value.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strap_wait_q <= 2'd0;
            strap_lat_q  <= 1'b0;
        end
        else if (ce && strap_wait_q != STRAP_END)
        begin
            strap_wait_q <= strap_wait_q + 2'd1;
            strap_lat_q  <= strap_s2_q;
        end
    end

    // Registers.
    logic [7:0] chan_pd_q, power_q, out_mode_q, user1_lo_q, user1_hi_q, user2_lo_q, user2_hi_q;
    logic [3:0] test_mode_q;
    logic [2:0] phase_q;
    qasoc_state_t state_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            chan_pd_q   <= RST_CHAN_PD;
            power_q     <= RST_POWER;
            test_mode_q <= RST_TEST_MODE;
            out_mode_q  <= RST_OUT_MODE;
            phase_q     <= RST_PHASE;
            user1_lo_q  <= RST_USER;
            user1_hi_q  <= RST_USER;
            user2_lo_q  <= RST_USER;
            user2_hi_q  <= RST_USER;
        end
        else if (ce && reg_wr)
        begin
            unique case (reg_addr)
                REG_CHAN_PD:   chan_pd_q   <= reg_wdata;
                REG_POWER:     power_q     <= reg_wdata;
                REG_TEST_MODE: test_mode_q <= reg_wdata[3:0];
                REG_OUT_MODE:  out_mode_q  <= reg_wdata;
                REG_PHASE:     phase_q     <= reg_wdata[2:0];
                REG_USER1_LO:  user1_lo_q  <= reg_wdata;
                REG_USER1_HI:  user1_hi_q  <= reg_wdata;
                REG_USER2_LO:  user2_lo_q  <= reg_wdata;
                REG_USER2_HI:  user2_hi_q  <= reg_wdata;
                default:       ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= 8'h00;
        end
        else if (ce)
        begin
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    REG_STATUS:    reg_rdata <= {3'b000, strap_lat_q, pd_s2_q, state_q};
                    REG_CHAN_PD:   reg_rdata <= chan_pd_q;
                    REG_POWER:     reg_rdata <= power_q;
                    REG_TEST_MODE: reg_rdata <= {4'h0, test_mode_q};
                    REG_OUT_MODE:  reg_rdata <= out_mode_q;
                    REG_PHASE:     reg_rdata <= {5'h00, phase_q};
                    REG_USER1_LO:  reg_rdata <= user1_lo_q;
                    REG_USER1_HI:  reg_rdata <= user1_hi_q;
                    REG_USER2_LO:  reg_rdata <= user2_lo_q;
                    REG_USER2_HI:  reg_rdata <= user2_hi_q;
                    default:       reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    logic [1:0] lc;
    assign lc = out_mode_q[OM_LEN_LO+1:OM_LEN_LO];

    // Power state. The deficit counter models reference charge lost while down:
    // it climbs while the pin holds the part off and is paid back on wake.
    logic [23:0] deficit_q;
    logic [4:0]  swake_q;
    logic        standby;
    assign standby = power_q[PW_STANDBY];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q   <= ST_OFF;
            deficit_q <= WAKE_MAX;
            swake_q   <= '0;
        end
        else if (ce)
        begin
            if (pd_s2_q)
            begin
                state_q <= ST_OFF;
                if (deficit_q != WAKE_MAX)
                    deficit_q <= deficit_q + 24'd1;
            end
            else
            begin
                unique case (state_q)
                    ST_OFF:   state_q <= ST_WAKE;
                    ST_WAKE:
                    begin
                        if (deficit_q == 24'd0)
                            state_q <= ST_RUN;
                        else
                            deficit_q <= deficit_q - 24'd1;
                    end
                    ST_RUN:   if (standby) state_q <= ST_STBY;
                    ST_STBY:
                    begin
                        if (!standby)
                        begin
                            state_q <= ST_SWAKE;
                            swake_q <= SWAKE_N - 5'd1;
                        end
                    end
                    ST_SWAKE:
                    begin
                        if (standby)
                            state_q <= ST_STBY;
                        else if (swake_q == 5'd0)
                            state_q <= ST_RUN;
                        else
                            swake_q <= swake_q - 5'd1;
                    end
                    default:  state_q <= ST_OFF;
                endcase
            end
        end
    end

    logic run;
    assign run = (state_q == ST_RUN);

    // Bit cell and word position counters.
    logic [2:0] cell_q;
    logic [3:0] bit_q;
    logic       load;
    logic [4:0] nbits;
    assign nbits = frame_bits(lc);
    assign load  = run && cell_q == 3'd0 && bit_q == 4'd0;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cell_q <= '0;
            bit_q  <= '0;
        end
        else if (ce)
        begin
            if (!run)
            begin
                cell_q <= '0;
                bit_q  <= '0;
            end
            else if (cell_q == CELL_END)
            begin
                cell_q <= '0;
                bit_q  <= ({1'b0, bit_q} == nbits - 5'd1) ? 4'd0 : bit_q + 4'd1;
            end
            else
                cell_q <= cell_q + 3'd1;
        end
    end

    // Pattern state advanced once per word.
    logic        alt_q;
    logic [22:0] pnl_q, pns_q;
    logic [36:0] pnl_nx, pns_nx;
    assign pnl_nx = pn_run(pnl_q, 23, 18, lc);
    assign pns_nx = pn_run(pns_q, 9, 5, lc);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            alt_q <= 1'b0;
            pnl_q <= PN_SEED;
            pns_q <= PN_SEED;
        end
        else if (ce && load)
        begin
            alt_q <= ~alt_q;
            if (test_mode_q == TM_PNL)
                pnl_q <= pnl_nx[36:14];
            if (test_mode_q == TM_PNS)
                pns_q <= pns_nx[36:14];
        end
    end

    // Test pattern word, right-justified at the selected length.
    logic [13:0] pat;
    logic        pat_fmt;
    always_comb
    begin
        pat     = '0;
        pat_fmt = 1'b0;
        case (test_mode_q)
            TM_MID:   begin pat = fit(PAT_MID, lc); pat_fmt = 1'b1; end
            TM_FULL:  begin pat = fit(PAT_ONES, lc); pat_fmt = 1'b1; end
            TM_ZERO:  pat_fmt = 1'b1;
            TM_CHECK: pat = fit(alt_q ? PAT_ALT_B : PAT_ALT_A, lc);
            TM_PNL:   begin pat = pnl_nx[13:0]; pat_fmt = 1'b1; end
            TM_PNS:   begin pat = pns_nx[13:0]; pat_fmt = 1'b1; end
            TM_WTOG:  pat = alt_q ? 14'h0000 : fit(PAT_ONES, lc);
            TM_USER:  pat = (alt_q ? {user2_hi_q[5:0], user2_lo_q}
                                   : {user1_hi_q[5:0], user1_lo_q}) & len_mask(lc);
            TM_BTOG:  pat = fit(PAT_ALT_A, lc);
            TM_SYNC:  pat = PAT_SYNC[lc];
            TM_HIGH:  pat = fit(PAT_MID, lc);
            TM_MIX:   pat = PAT_MIX[lc];
            default:  ;
        endcase
    end

    // Clock generation. A 12-cycle bit clock period gives 30 degrees per cycle.
    logic [3:0] pos, off, ph;
    logic       half;
    assign pos  = (bit_q[0] ? 4'd6 : 4'd0) + {1'b0, cell_q};
    assign off  = (phase_q == 3'd0 || phase_q == 3'd7) ? 4'(PHASE_DEF_CYC)
                : 4'(PHASE_STEP_CYC) * ({1'b0, phase_q} - 4'd1);
    assign ph   = (pos >= off) ? pos - off : pos + 4'd12 - off;
    assign half = {1'b0, bit_q} < (nbits >> 1);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bit_clock_output   <= 1'b0;
            frame_clock_output <= 1'b0;
        end
        else if (ce)
        begin
            bit_clock_output   <= run && ph < 4'd6;
            frame_clock_output <= run && half;
        end
    end

    // Per-lane word build and shifter.
    logic [15:0] sh_q [NCH];

    for (genvar c = 0; c < NCH; c++)
    begin : g_lane
        logic [13:0] w;
        logic [15:0] img, rev;
        always_comb
        begin
            w = (test_mode_q == TM_OFF)
              ? ({6'h00, adc_data[c*8 +: 8]} << {lc, 1'b0}) : pat;
            if ((test_mode_q == TM_OFF || pat_fmt) && out_mode_q[OM_TWOS])
                w = w ^ fit(PAT_MID, lc);
            img = {w, 2'b00} << (4'd6 - {1'b0, lc, 1'b0});
            for (int i = 0; i < 16; i++)
                rev[i] = img[15-i];
            if (out_mode_q[OM_LSB_1ST])
                img = rev << (4'd8 - {1'b0, lc, 1'b0});
        end

        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                sh_q[c]      <= '0;
                lane_data[c] <= 1'b0;
            end
            else if (ce)
            begin
                if (!run || chan_pd_q[c])
                begin
                    lane_data[c] <= 1'b0;
                    sh_q[c]      <= '0;
                end
                else if (load)
                begin
                    lane_data[c] <= img[15];
                    sh_q[c]      <= img << 1;
                end
                else if (cell_q == 3'd0)
                begin
                    lane_data[c] <= sh_q[c][15];
                    sh_q[c]      <= sh_q[c] << 1;
                end
            end
        end
    end

    // Drivers and analog controls.
    logic hiz_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            hiz_q <= 1'b1;
        else if (ce)
            hiz_q <= (state_q == ST_OFF) || pd_s2_q;
    end

    assign lane_oe_n               = {NCH{hiz_q}};
    assign bit_clock_output_oe_n   = hiz_q;
    assign frame_clock_output_oe_n = hiz_q;
    assign sample_take             = load && ce;
    assign low_swing     = strap_lat_q | out_mode_q[OM_LOW_SWNG];
    assign high_drive    = out_mode_q[OM_HI_DRIVE];
    assign pll_low_rate  = out_mode_q[OM_LOW_PLL];
    assign pll_enable    = state_q != ST_OFF;
    assign analog_enable = state_q != ST_OFF && state_q != ST_STBY;

endmodule : qasoc_top

// ===== core/qasoc_pkg.sv
package qasoc_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] REG_STATUS    = 8'h02;
    localparam logic [7:0] REG_CHAN_PD   = 8'h05;
    localparam logic [7:0] REG_POWER     = 8'h08;
    localparam logic [7:0] REG_TEST_MODE = 8'h0D;
    localparam logic [7:0] REG_OUT_MODE  = 8'h14;
    localparam logic [7:0] REG_PHASE     = 8'h16;
    localparam logic [7:0] REG_USER1_LO  = 8'h19;
    localparam logic [7:0] REG_USER1_HI  = 8'h1A;
    localparam logic [7:0] REG_USER2_LO  = 8'h1B;
    localparam logic [7:0] REG_USER2_HI  = 8'h1C;

    // Field positions in the output mode and power registers.
    localparam int OM_TWOS     = 0;
    localparam int OM_LOW_SWNG = 1;
    localparam int OM_HI_DRIVE = 2;
    localparam int OM_LSB_1ST  = 3;
    localparam int OM_LEN_LO   = 4;
    localparam int OM_LOW_PLL  = 6;
    localparam int PW_STANDBY  = 0;

    // Values after reset.
    localparam logic [7:0] RST_CHAN_PD   = 8'h00;
    localparam logic [7:0] RST_POWER     = 8'h00;
    localparam logic [3:0] RST_TEST_MODE = 4'h0;
    localparam logic [7:0] RST_OUT_MODE  = 8'h00;
    localparam logic [2:0] RST_PHASE     = 3'h0;
    localparam logic [7:0] RST_USER      = 8'h00;

    // Timing, clock at 25 MHz.
    localparam int CLK_PERIOD_NS  = 40;
    localparam int WAKE_TIME_US   = 375;
    localparam int WAKE_CYC       = WAKE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int STBY_WAKE_NS   = 600;
    localparam int STBY_WAKE_CYC  = (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CELL_CYC       = 6;
    localparam int PHASE_STEP_CYC = 2;
    localparam int PHASE_DEF_CYC  = 3;
    localparam int STRAP_SYNC_CYC = 3;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_WAKE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_STBY  = 3'b011,
        ST_SWAKE = 3'b100
    } qasoc_state_t;

    typedef enum logic [3:0] {
        TM_OFF   = 4'h0,
        TM_MID   = 4'h1,
        TM_FULL  = 4'h2,
        TM_ZERO  = 4'h3,
        TM_CHECK = 4'h4,
        TM_PNL   = 4'h5,
        TM_PNS   = 4'h6,
        TM_WTOG  = 4'h7,
        TM_USER  = 4'h8,
        TM_BTOG  = 4'h9,
        TM_SYNC  = 4'hA,
        TM_HIGH  = 4'hB,
        TM_MIX   = 4'hC
    } qasoc_tmode_t;

    // 14-bit forms; shorter word lengths take the top bits.
    localparam logic [13:0] PAT_MID   = 14'h2000;
    localparam logic [13:0] PAT_ONES  = 14'h3FFF;
    localparam logic [13:0] PAT_ALT_A = 14'h2AAA;
    localparam logic [13:0] PAT_ALT_B = 14'h1555;
    // These two differ in shape per length, indexed by length code 8/10/12/14.
    localparam logic [13:0] PAT_SYNC [4] = '{14'h000F, 14'h001F, 14'h003F, 14'h007F};
    localparam logic [13:0] PAT_MIX  [4] = '{14'h00A3, 14'h0263, 14'h0A33, 14'h2867};
    localparam logic [22:0] PN_SEED = 23'h7FFFFF;

endpackage : qasoc_pkg

// ===== dv/qasoc_top_checker.sv
`timescale 1ns/1ps
module qasoc_top_checker
    import qasoc_pkg::*;
#(
    parameter int NCH = 4
)(
    input wire logic           clk,
    input wire logic           resetn,
    input wire logic [7:0]     reg_addr,
    input wire logic [7:0]     reg_wdata,
    input wire logic           reg_wr,
    input wire logic           power_down_pin,
    input wire logic           sample_take,
    input wire logic [NCH-1:0] lane_data,
    input wire logic [NCH-1:0] lane_oe_n,
    input wire logic           bit_clock_output,
    input wire logic           frame_clock_output_oe_n,
    input wire logic           frame_clock_output,
    input wire logic           low_swing,
    input wire logic           high_drive,
    input wire logic           pll_low_rate,
    input wire logic           pll_enable,
    input wire logic           analog_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [NCH-1:0] chpd_q;
    logic           wr_om;
    logic           wr_pw;
    assign wr_om = reg_wr && reg_addr == REG_OUT_MODE;
    assign wr_pw = reg_wr && reg_addr == REG_POWER;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            chpd_q <= '0;
        else if (reg_wr && reg_addr == REG_CHAN_PD)
            chpd_q <= reg_wdata[NCH-1:0];
    end

    // Six samples cover the two-stage synchroniser plus the state change.
    sequence s_pd_held; power_down_pin[*6]; endsequence
    sequence s_frame_word; frame_clock_output[*8] ##17 !frame_clock_output; endsequence
    sequence s_bclk; bit_clock_output ##6 !bit_clock_output ##6 bit_clock_output; endsequence

    property p_pd_hiz; s_pd_held |-> &lane_oe_n && frame_clock_output_oe_n; endproperty
    a_pd_hiz: assert property (p_pd_hiz) else $error("drivers not released");
    property p_pd_off; s_pd_held |-> !pll_enable && !analog_enable; endproperty
    a_pd_off: assert property (p_pd_off) else $error("analog still on");
    property p_pd_wake;
        s_pd_held ##1 !power_down_pin |-> (!sample_take)[*3] ##[1:300] sample_take;
    endproperty
    a_pd_wake: assert property (p_pd_wake) else $error("no wake after pin low");
    property p_stby;
        wr_pw && reg_wdata[PW_STANDBY] && analog_enable |-> ##[1:4] (pll_enable && !analog_enable);
    endproperty
    a_stby: assert property (p_stby) else $error("standby state wrong");
    property p_swake;
        wr_pw && !reg_wdata[PW_STANDBY] && pll_enable && !analog_enable |-> ##[1:80] sample_take;
    endproperty
    a_swake: assert property (p_swake) else $error("slow standby wake");
    property p_frame; sample_take |=> s_frame_word; endproperty
    a_frame: assert property (p_frame) else $error("frame clock misaligned");
    property p_bclk; sample_take |-> ##4 s_bclk; endproperty
    a_bclk: assert property (p_bclk) else $error("bit clock rate wrong");
    property p_chpd; sample_take && chpd_q[0] |=> (lane_data[0] == 1'b0)[*6]; endproperty
    a_chpd: assert property (p_chpd) else $error("idle lane moved");
    property p_drive; wr_om |=> high_drive == $past(reg_wdata[OM_HI_DRIVE]); endproperty
    a_drive: assert property (p_drive) else $error("drive option wrong");
    property p_pll; wr_om |=> pll_low_rate == $past(reg_wdata[OM_LOW_PLL]); endproperty
    a_pll: assert property (p_pll) else $error("pll option wrong");
    property p_swing; wr_om && reg_wdata[OM_LOW_SWNG] |=> low_swing; endproperty
    a_swing: assert property (p_swing) else $error("swing option wrong");
endmodule : qasoc_top_checker

bind qasoc_top qasoc_top_checker #(.NCH(NCH)) qasoc_top_checker_i (
    .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .power_down_pin, .sample_take,
    .lane_data, .lane_oe_n, .bit_clock_output, .frame_clock_output_oe_n,
    .frame_clock_output, .low_swing, .high_drive, .pll_low_rate, .pll_enable, .analog_enable
);

// ===== dv/qasoc_rx_model.sv
`timescale 1ns/1ps
module qasoc_rx_model (
    input  wire logic        bit_clock_output,
    input  wire logic        frame_clock_output,
    input  wire logic [3:0]  lane_data,
    output logic      [31:0] words,
    output int               word_cnt
);
    logic [31:0] sh = 32'h0;
    logic        fr_q = 1'b0;
    int          nb = 0;
    initial words = 32'h0;
    initial word_cnt = 0;
    // Both edges of the bit clock carry a bit, so capture runs on every transition.
    always @(bit_clock_output)
    begin
        if (frame_clock_output && !fr_q)
            nb = 0;
        fr_q = frame_clock_output;
        for (int c = 0; c < 4; c++)
            sh[c*8 +: 8] = {sh[c*8 +: 7], lane_data[c]};
        nb++;
        if (nb == 8)
        begin
            words = sh;
            word_cnt++;
        end
    end
endmodule : qasoc_rx_model

// ===== dv/test_quad_adc_serial_output_ctrl.sv
`timescale 1ns/1ps
module test_quad_adc_serial_output_ctrl;
    import qasoc_pkg::*;
    localparam int WAKE_SIM = 20;
    // Entries are {test mode, output mode, first word, second word}.
    localparam logic [23:0] TV [14] = '{24'h005C5C, 24'h01DCDC, 24'h108080, 24'h110000,
        24'h217F7F, 24'h318080, 24'h41AA55, 24'h71FF00, 24'h813CC3, 24'h91AAAA,
        24'hA10F0F, 24'hB18080, 24'hC1A3A3, 24'hA9F0F0};
    logic        clk, resetn, ce, reg_wr, reg_rd, power_down_pin, sample_take;
    logic        bit_clock_output, bit_clock_output_oe_n, frame_clock_output;
    logic        frame_clock_output_oe_n, low_swing, high_drive, pll_low_rate;
    logic        pll_enable, analog_enable, strap;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [3:0]  lane_data, lane_oe_n;
    logic [31:0] adc_data, words;
    int          word_cnt, fails, samples_checked;

    qasoc_top #(.NCH(4), .WAKE_CYCLES(WAKE_SIM)) qasoc_top_i (
        .clk, .resetn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .power_down_pin, .serial_io_drive_mode_strap(strap), .adc_data, .sample_take,
        .lane_data, .lane_oe_n, .bit_clock_output, .bit_clock_output_oe_n,
        .frame_clock_output, .frame_clock_output_oe_n, .low_swing, .high_drive,
        .pll_low_rate, .pll_enable, .analog_enable
    );
    qasoc_rx_model qasoc_rx_model_i (.bit_clock_output, .frame_clock_output, .lane_data,
        .words, .word_cnt);

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk8($sformatf("register %h", a), e, reg_rdata);
        @(posedge clk);
    endtask : rchk

    task automatic wait_take(output int n);
        n = 0;
        @(negedge clk);
        while (sample_take !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk1("word load seen", 1'b1, n < 300);
        @(posedge clk);
    endtask : wait_take

    task automatic get_word(output logic [31:0] w);
        int c;
        int k;
        c = word_cnt;
        k = 0;
        while (word_cnt == c && k < 300)
        begin
            @(posedge clk);
            k++;
        end
        chk1("word received", 1'b1, k < 300);
        w = words;
    endtask : get_word

    // Disruptive writes land after the frame and bit clock checks of the word have ended.
    task automatic sync_word;
        int n;
        wait_take(n);
        repeat (30) @(posedge clk);
    endtask : sync_word

    task automatic tmode(input logic [3:0] m, input logic [7:0] om, input logic [7:0] e1,
                         input logic [7:0] e2);
        logic [31:0] a, b, t;
        wr(REG_OUT_MODE, om);
        wr(REG_TEST_MODE, {4'h0, m});
        get_word(a);
        get_word(a);
        get_word(b);
        if (a[7:0] !== e1)
        begin
            t = a;
            a = b;
            b = t;
        end
        chk8($sformatf("mode %h lane0 first", m), e1, a[7:0]);
        chk8($sformatf("mode %h lane0 second", m), e2, b[7:0]);
        chk8($sformatf("mode %h lane3 first", m), e1, a[31:24]);
    endtask : tmode

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        fails++;
        $display("ERROR watchdog expected end of tests seen timeout");
        final_report;
    end

    initial
    begin
        logic [31:0] w;
        int          n;
        resetn = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        power_down_pin = 1'b0;
        strap = 1'b0;
        adc_data = {4{8'h5C}};
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rchk(REG_OUT_MODE, 8'h00);
        chk1("swing default", 1'b0, low_swing);
        rchk(REG_TEST_MODE, 8'h00);
        rchk(REG_CHAN_PD, 8'h00);
        rchk(REG_POWER, 8'h00);
        rchk(8'hFF, 8'h00);
        wait_take(n);
        rchk(REG_STATUS, {5'h00, ST_RUN});
        chk8("lane oe_n run", 8'h00, {4'h0, lane_oe_n});
        wr(REG_OUT_MODE, 8'h46);
        @(negedge clk);
        chk1("high_drive", 1'b1, high_drive);
        chk1("pll_low_rate", 1'b1, pll_low_rate);
        chk1("low_swing", 1'b1, low_swing);
        @(posedge clk);
        // Either alignment of the 14-bit user word yields the same byte here.
        wr(REG_USER1_LO, 8'h3C);
        wr(REG_USER1_HI, 8'h0F);
        wr(REG_USER2_LO, 8'hC3);
        wr(REG_USER2_HI, 8'h30);
        for (int i = 0; i < 14; i++)
            tmode(TV[i][23:20], {4'h0, TV[i][19:16]}, TV[i][15:8], TV[i][7:0]);
        wr(REG_PHASE, 8'h02);
        wr(REG_OUT_MODE, 8'h00);
        wr(REG_TEST_MODE, 8'h02);
        wr(REG_CHAN_PD, 8'h01);
        get_word(w);
        get_word(w);
        chk8("idle lane0", 8'h00, w[7:0]);
        chk8("live lane1", 8'hFF, w[15:8]);
        wr(REG_CHAN_PD, 8'h00);
        sync_word;
        wr(REG_POWER, 8'h01);
        rchk(REG_STATUS, {5'h00, ST_STBY});
        chk1("pll kept in standby", 1'b1, pll_enable);
        wr(REG_POWER, 8'h00);
        wait_take(n);
        chk1("fast standby wake", 1'b1, n <= STBY_WAKE_CYC + 2);
        sync_word;
        power_down_pin <= 1'b1;
        repeat (40) @(posedge clk);
        chk8("lane oe_n", 8'h0F, {4'h0, lane_oe_n});
        chk1("clock oe_n", 1'b1, bit_clock_output_oe_n & frame_clock_output_oe_n);
        chk1("analog on", 1'b0, analog_enable | pll_enable);
        rchk(REG_STATUS, {4'h0, 1'b1, ST_OFF});
        power_down_pin <= 1'b0;
        wait_take(n);
        chk1("full wake time", 1'b1, n >= WAKE_SIM);
        resetn <= 1'b0;
        strap <= 1'b1;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk1("strap swing", 1'b1, low_swing);
        rchk(REG_STATUS, {3'h0, 1'b1, 1'b0, ST_WAKE});
        final_report;
    end
endmodule : test_quad_adc_serial_output_ctrl
